/* safe_torque_cutoff_gate.sv */
`timescale 1ns/100ps
`include "stcg_cfg.svh"
module safe_torque_cutoff_gate
   import stcg_pkg::*;
#(
   parameter int PWM_W = 6,
   parameter int FILT_CYC = `STCG_FILT_CYC,
   parameter int MS_CYC = `STCG_MS_CYC,
   parameter int OPEN_MS = `STCG_OPEN_MS,
   parameter int DIAG_CYC = `STCG_DIAG_CYC
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic torque_permit_in_a,
   input wire logic torque_permit_in_b,
   input wire logic [PWM_W-1:0] pwmIn,
   input wire logic [PWM_W-1:0] pwmReadback,
   input wire logic servoOn,
   output logic [PWM_W-1:0] pwmOut,
   output logic external_monitor_out,
   output logic safe_state_indication,
   output logic servoReady,
   output logic input_open_alarm,
   output logic cutoff_circuit_fault_alarm,
   output logic testPulse
);
   localparam int TEST_CYC = `STCG_TEST_CYC;

   typedef struct packed {
      stcg_mode_e mode;
      logic [PWM_W-1:0] pwm;
      logic monitor;
      logic safeInd;
      logic ready;
      logic openAlarm;
      logic faultAlarm;
      logic testPulse;
      stcg_cnt_t msDiv;
      logic [15:0] openMs;
      stcg_cnt_t diagCnt;
      logic [3:0] testCnt;
   } stcg_top_s;
   stcg_top_s st;
   stcg_top_s next_st;

   logic permitA;
   logic permitB;
   logic bothOk;
   logic anyOpen;
   logic msTick;
   logic testFail;

   // readback is synchronous to the pwm stage, so no synchroniser
   function automatic logic [PWM_W-1:0] gatePwm(input logic en,
      input logic [PWM_W-1:0] p);
      gatePwm = en ? p : '0;
   endfunction : gatePwm

   // two independent filtered channels
   stcg_filter #(.FILT_CYC(FILT_CYC)) chanA (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pinIn(torque_permit_in_a),
      .permit(permitA)
   );
   stcg_filter #(.FILT_CYC(FILT_CYC)) chanB (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pinIn(torque_permit_in_b),
      .permit(permitB)
   );

   // either channel alone can block the gate
   assign bothOk = permitA & permitB;
   assign anyOpen = ~permitA | ~permitB;
   assign msTick = (st.msDiv == stcg_cnt_t'(MS_CYC - 1));
   // during a test pulse the gate is closed, so any live readback
   // means the cutoff path is stuck on
   assign testFail = st.testPulse && (pwmReadback != '0);

   always_comb begin
      next_st = st;
      next_st.msDiv = msTick ? '0 : st.msDiv + stcg_cnt_t'(1);
      // open-time counter in ms, saturates at the alarm point
      if (!anyOpen) begin
         next_st.openMs = '0;
      end else if (msTick && st.openMs <= 16'(OPEN_MS)) begin
         next_st.openMs = st.openMs + 16'd1;
      end
      // set needs a live open input, so a restored input never raises it
      if (anyOpen && st.openMs > 16'(OPEN_MS)) begin
         next_st.openAlarm = 1'b1;
      end else if (!anyOpen) begin
         next_st.openAlarm = 1'b0;
      end
      // periodic cutoff self-test, well under 20 ms apart
      next_st.testPulse = 1'b0;
      if (st.testCnt != '0) begin
         next_st.testCnt = st.testCnt - 4'd1;
         next_st.testPulse = 1'b1;
      end else if (st.diagCnt >= stcg_cnt_t'(DIAG_CYC - 1)) begin
         next_st.diagCnt = '0;
         next_st.testCnt = 4'(TEST_CYC);
      end else begin
         next_st.diagCnt = st.diagCnt + stcg_cnt_t'(1);
      end
      if (testFail) begin
         next_st.faultAlarm = 1'b1;
      end
      unique case (st.mode)
         STCG_RUN: begin
            if (!bothOk) begin
               next_st.mode = STCG_SAFE;
            end
         end
         STCG_SAFE: begin
            if (bothOk) begin
               next_st.mode = STCG_RUN;
            end
         end
         STCG_FAULT: begin
            next_st.mode = STCG_FAULT;
         end
         default: begin
            next_st.mode = STCG_FAULT;
         end
      endcase
      // a fault latches until reset; only a restart clears it
      if (testFail || st.faultAlarm) begin
         next_st.mode = STCG_FAULT;
      end
      // gate uses the live permits too, so a drop blocks next edge
      next_st.pwm = gatePwm(next_st.mode == STCG_RUN && bothOk &&
         !next_st.testPulse, pwmIn);
      next_st.safeInd = (next_st.mode != STCG_RUN);
      next_st.monitor = ~permitA & ~permitB & !st.faultAlarm;
      next_st.ready = (next_st.mode == STCG_RUN) && !servoOn;
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         st <= '0;
         st.mode <= STCG_SAFE;
         st.safeInd <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign pwmOut = st.pwm;
   assign external_monitor_out = st.monitor;
   assign safe_state_indication = st.safeInd;
   assign servoReady = st.ready;
   assign input_open_alarm = st.openAlarm;
   assign cutoff_circuit_fault_alarm = st.faultAlarm;
   assign testPulse = st.testPulse;

   sequence stcgChanDrop;
      !bothOk;
   endsequence
   sequence stcgBlocked;
      ##1 pwmOut == '0;
   endsequence

   AST_DROP_BLOCKS: assert property (@(posedge ref_clk) disable iff (!nrst)
      stcgChanDrop |-> stcgBlocked)
      else $error("pwm not blocked after channel drop");
   AST_PASS_ONLY_BOTH: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      pwmOut != '0 |-> $past(bothOk))
      else $error("pwm passed without both permits");
   AST_SAFE_ALL_OFF: assert property (@(posedge ref_clk) disable iff (!nrst)
      safe_state_indication |-> pwmOut == '0)
      else $error("pwm active in safe state");
   AST_SAFE_NOT_READY: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      safe_state_indication |-> !servoReady)
      else $error("ready high in safe state");
   AST_FAULT_SAFE: assert property (@(posedge ref_clk) disable iff (!nrst)
      testFail |=> ##1 st.mode == STCG_FAULT && pwmOut == '0)
      else $error("fault did not force safe state");
   AST_FAULT_FLAG: assert property (@(posedge ref_clk) disable iff (!nrst)
      testFail |=> cutoff_circuit_fault_alarm)
      else $error("circuit fault alarm not raised");
   AST_MONITOR: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (!permitA && !permitB && !st.faultAlarm) |=> external_monitor_out)
      else $error("monitor not raised");
   AST_RESUME: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (st.mode == STCG_SAFE && bothOk && !testFail) |=>
      st.mode == STCG_RUN)
      else $error("safe state not left on both permits");
   AST_OPEN_ALARM: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(input_open_alarm) |-> $past(anyOpen))
      else $error("open alarm without open input");
   AST_DIAG_PERIOD: assert property (@(posedge ref_clk) disable iff (!nrst)
      st.diagCnt < stcg_cnt_t'(DIAG_CYC))
      else $error("diagnostic interval overrun");

   // self-test pulse body: four closed cycles, then the gate reopens
   sequence stcgPulseBody;
      testPulse [*4] ##1 !testPulse;
   endsequence
   sequence stcgHeldSafe;
      safe_state_indication && pwmOut == '0;
   endsequence

   // reset is the safe state, whatever came before
   AST_RESET_SAFE: assert property (@(posedge ref_clk)
      !nrst |=> stcgHeldSafe and !servoReady)
      else $error("reset did not give the safe state");

   // running with a channel gone must close the gate at the next edge
   AST_RUN_DROP: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (st.mode == STCG_RUN && !bothOk) |=> stcgHeldSafe)
      else $error("cutoff slower than one cycle after permit loss");

   // a lost channel always shows up as safe indication
   AST_DROP_SAFE_IND: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      !bothOk |=> safe_state_indication)
      else $error("safe indication missing after permit loss");

   // ready must fall with the permits, or the host may re-enable
   AST_DROP_READY: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      !bothOk |=> !servoReady)
      else $error("ready high after permit loss");

   // ready only while running and the servo is off
   AST_READY_NEEDS_RUN: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      servoReady |-> st.mode == STCG_RUN && $past(!servoOn))
      else $error("ready without run state");

   // run is only ever entered with both permits up
   AST_RUN_ENTRY: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      st.mode == STCG_RUN |-> $past(bothOk))
      else $error("run state without both permits");

   // a latched fault keeps the gate shut until reset
   AST_FAULT_NO_PWM: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      st.mode == STCG_FAULT |-> stcgHeldSafe)
      else $error("pwm active in fault state");

   // no way out of the fault state except reset
   AST_FAULT_HELD: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      st.mode == STCG_FAULT |=> st.mode == STCG_FAULT)
      else $error("fault state left without reset");

   // the fault alarm is sticky
   AST_FAULT_LATCH: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      cutoff_circuit_fault_alarm |=> cutoff_circuit_fault_alarm)
      else $error("fault alarm dropped without reset");

   // monitor means healthy cutoff, so a fault must silence it
   AST_FAULT_NOT_MON: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      cutoff_circuit_fault_alarm |=> !external_monitor_out)
      else $error("monitor high with fault alarm");

   // one permit still up means no monitor
   AST_MON_OFF: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (permitA || permitB) |=> !external_monitor_out)
      else $error("monitor high with a permit up");

   // the gate is closed for the whole test pulse
   AST_TEST_GATE: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      testPulse |-> pwmOut == '0)
      else $error("pwm live during test pulse");

   // pulse width is fixed, so the readback check window is known
   AST_TEST_WIDTH: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      $rose(testPulse) |-> stcgPulseBody)
      else $error("test pulse width wrong");

   // the open alarm clears once both channels permit again
   AST_OPEN_CLEAR: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      !anyOpen |=> !input_open_alarm)
      else $error("open alarm kept with inputs closed");

   // the alarm only stands once the open time is past its limit
   AST_OPEN_TIME: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      input_open_alarm |-> st.openMs > 16'(OPEN_MS))
      else $error("open alarm before the open time ran out");
endmodule : safe_torque_cutoff_gate

/* stcg_cfg.svh */
`ifndef STCG_CFG_SVH
`define STCG_CFG_SVH
// clock period in ns
`define STCG_CLK_NS 20
// low-time filter threshold, in us
`define STCG_FILT_US 2000
// filter count in cycles, low must exceed this
`define STCG_FILT_CYC ((`STCG_FILT_US * 1000) / `STCG_CLK_NS)
// input-open alarm time, in ms (taken on 1 ms ticks)
`define STCG_OPEN_MS 10000
// 1 ms tick divider length in cycles
`define STCG_MS_CYC (1000000 / `STCG_CLK_NS)
// diagnostic test interval, in us (below 20 ms)
`define STCG_DIAG_US 10000
`define STCG_DIAG_CYC ((`STCG_DIAG_US * 1000) / `STCG_CLK_NS)
// self-test pulse width in cycles
`define STCG_TEST_CYC 4
`endif

/* stcg_filter.sv */
`timescale 1ns/100ps
`include "stcg_cfg.svh"
// one channel: 3-flop sync, agree check, continuous-low filter
module stcg_filter
   import stcg_pkg::*;
#(
   parameter int FILT_CYC = `STCG_FILT_CYC
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic pinIn,
   output logic permit
);
   typedef struct packed {
      logic [2:0] sync;
      logic level;
      stcg_cnt_t lowCnt;
      logic permit;
   } stcg_flt_s;
   stcg_flt_s st;
   stcg_flt_s next_st;

   // sync[0] feeds only sync[1]; level moves when sync[1] and sync[2] agree
   always_comb begin
      next_st = st;
      next_st.sync = {st.sync[1:0], pinIn};
      if (st.sync[2] == st.sync[1]) begin
         next_st.level = st.sync[2];
      end
      if (st.level) begin
         next_st.lowCnt = '0;
         next_st.permit = 1'b1;
      end else if (st.lowCnt > stcg_cnt_t'(FILT_CYC)) begin
         next_st.permit = 1'b0;
      end else begin
         next_st.lowCnt = st.lowCnt + stcg_cnt_t'(1);
      end
   end

   // reset starts blocked, so torque waits for a confirmed high
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign permit = st.permit;

   AST_FILT_HIGH_CLEARS: assert property (@(posedge ref_clk) disable iff (!nrst)
      st.level |=> st.lowCnt == '0 && st.permit)
      else $error("filter count not cleared on high");
   // a low no longer than the threshold must not drop the channel
   AST_FILT_LOW_HOLD: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (st.permit && st.lowCnt <= stcg_cnt_t'(FILT_CYC)) |=> st.permit)
      else $error("channel dropped on a short low");
   AST_FILT_DROP: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (!st.level && st.lowCnt > stcg_cnt_t'(FILT_CYC)) |=> !st.permit)
      else $error("channel kept after a long low");
endmodule : stcg_filter

/* stcg_pkg.sv */
package stcg_pkg;
   typedef enum logic [1:0] {
      STCG_RUN = 2'b00,
      STCG_SAFE = 2'b01,
      STCG_FAULT = 2'b10
   } stcg_mode_e;
   typedef logic [21:0] stcg_cnt_t;
endpackage : stcg_pkg

/* stcg_safety_ctrl.sv */
`timescale 1ns/100ps
// far-side safety controller: two permit contacts, plus a short low
// self-test pulse on both channels when asked
module stcg_safety_ctrl #(
   parameter int PULSE_CYC = 12
) (
   input wire logic ref_clk,
   input wire logic reqA,
   input wire logic reqB,
   input wire logic pulseReq,
   output logic permitA,
   output logic permitB
);
   int pulseCnt = 0;
   // pulse kept under the filter time so the drive has to ignore it
   always @(posedge ref_clk) begin
      if (pulseReq) begin
         pulseCnt <= PULSE_CYC;
      end else if (pulseCnt > 0) begin
         pulseCnt <= pulseCnt - 1;
      end
   end
   // contacts open on a stop request or during the self-test pulse
   assign permitA = reqA && (pulseCnt == 0);
   assign permitB = reqB && (pulseCnt == 0);
endmodule : stcg_safety_ctrl

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import stcg_pkg::*;
   logic ref_clk = 0, nrst = 0, reqA = 0, reqB = 0, pulseReq = 0;
   logic servoOn = 0, permitA, permitB, testPulse;
   logic mon, safe, rdy, openAl, faultAl;
   logic [5:0] pwmIn = 6'h00, pwmOut, stuck = 6'h00;
   logic [10:0] expQ[$];
   event seen;
   int err_count = 0, total_checks = 0, seed = 8718, k;
   // power stage sense: a stuck gate shows up even with the gate closed
   wire logic [5:0] readback = pwmOut | stuck;

   stcg_safety_ctrl ctrl (.ref_clk(ref_clk), .reqA(reqA), .reqB(reqB),
      .pulseReq(pulseReq), .permitA(permitA), .permitB(permitB));
   // short counts keep the run small; expectations follow from them
   safe_torque_cutoff_gate #(.PWM_W(6), .FILT_CYC(20), .MS_CYC(10),
      .OPEN_MS(5), .DIAG_CYC(50)) uut (.ref_clk(ref_clk), .nrst(nrst),
      .torque_permit_in_a(permitA), .torque_permit_in_b(permitB),
      .pwmIn(pwmIn), .pwmReadback(readback), .servoOn(servoOn),
      .pwmOut(pwmOut), .external_monitor_out(mon),
      .safe_state_indication(safe), .servoReady(rdy),
      .input_open_alarm(openAl), .cutoff_circuit_fault_alarm(faultAl),
      .testPulse(testPulse));

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   task check(input string name, input logic [10:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask : check

   task tally_and_finish;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   // inputs move a fixed 2 ns after the rising edge
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : cyc

   // step past any diagnostic pulse, which also closes the gate
   task calm;
      k = 0;
      while (k < 2) begin
         cyc(1);
         k = testPulse ? 0 : k + 1;
      end
   endtask : calm

   // expected {safe, monitor, ready, open, fault, pwm}
   task note(input logic [10:0] e);
      expQ.push_back(e);
      ->seen;
   endtask : note

   task newPwm;
      pwmIn = 6'($random(seed)) | 6'h01;
   endtask : newPwm

   // watcher compares outputs against the oldest note
   initial begin
      forever begin
         @(seen);
         check("outs", {safe, mon, rdy, openAl, faultAl, pwmOut},
            expQ.pop_front());
      end
   end

   initial begin
      cyc(12);
      nrst = 1;
      reqA = 1;
      reqB = 1;
      newPwm;
      cyc(10);
      calm;
      note({5'b00100, pwmIn});
      servoOn = 1;
      cyc(2);
      calm;
      note({5'b00000, pwmIn});
      servoOn = 0;
      // two short lows with a brief high between: sum over the filter
      pulseReq = 1;
      cyc(1);
      pulseReq = 0;
      cyc(15);
      pulseReq = 1;
      cyc(1);
      pulseReq = 0;
      cyc(15);
      calm;
      note({5'b00100, pwmIn});
      // either channel alone, all gate lines asked high
      for (int ch = 0; ch < 2; ch++) begin
         pwmIn = 6'h3F;
         reqA = (ch != 0);
         reqB = (ch == 0);
         cyc(40);
         note({5'b10000, 6'h00});
         reqA = 1;
         reqB = 1;
         newPwm;
         cyc(12);
         calm;
         note({5'b00100, pwmIn});
      end
      reqA = 0;
      reqB = 0;
      cyc(35);
      note({5'b11000, 6'h00});
      cyc(60);
      note({5'b11010, 6'h00});
      reqA = 1;
      reqB = 1;
      cyc(12);
      calm;
      note({5'b00100, pwmIn});
      // stuck gate seen at the next diagnostic pulse
      stuck = 6'h01;
      k = 0;
      while (!testPulse && k < 60) begin
         cyc(1);
         k++;
      end
      check("diag", {10'h000, testPulse}, 11'h001);
      cyc(10);
      note({5'b10001, 6'h00});
      cyc(20);
      note({5'b10001, 6'h00});
      stuck = 6'h00;
      nrst = 0;
      cyc(5);
      note({5'b10000, 6'h00});
      nrst = 1;
      cyc(12);
      calm;
      note({5'b00100, pwmIn});
      // let the watcher take the last note before the verdict
      cyc(1);
      tally_and_finish;
   end

   // the sequence needs well under 1000 cycles
   initial begin
      repeat (2000) @(posedge ref_clk);
      err_count++;
      tally_and_finish;
   end
endmodule : tb_top
